// *** shared/drmc_pkg.sv ***
// Constants, register map and state codes of the DRAM refresh mode control block
package drmc_pkg;

    localparam int unsigned DRMC_ADDR_W = 8;
    localparam int unsigned DRMC_DATA_W = 32;
    localparam int unsigned DRMC_EXT_ADDR_W = 27;

    // Register byte offsets
    localparam logic [DRMC_ADDR_W-1:0] DRMC_OFS_MODE = 8'h00;
    localparam logic [DRMC_ADDR_W-1:0] DRMC_OFS_COUNT = 8'h04;
    localparam logic [DRMC_ADDR_W-1:0] DRMC_OFS_CONST = 8'h08;
    localparam logic [DRMC_ADDR_W-1:0] DRMC_OFS_TCTRL = 8'h0C;
    localparam logic [DRMC_ADDR_W-1:0] DRMC_OFS_STATUS = 8'h10;

    // Mode register fields
    localparam int unsigned DRMC_BIT_EDO = 0;
    localparam int unsigned DRMC_BIT_KIND = 1;
    localparam int unsigned DRMC_BIT_ENABLE = 2;
    localparam int unsigned DRMC_BIT_WIDE_BUS = 3;
    localparam logic DRMC_RST_BIT = 1'h0;

    // Timer control fields
    localparam int unsigned DRMC_SEL_W = 3;
    localparam int unsigned DRMC_SEL_LSB = 0;
    localparam int unsigned DRMC_BIT_MATCH = 7;

    // Status fields
    localparam int unsigned DRMC_STATE_W = 3;
    localparam int unsigned DRMC_BIT_OVERRUN = 4;
    localparam int unsigned DRMC_BIT_SELF = 5;

    // Bank address bits for the 256K x 32 x 2-bank organisation
    localparam int unsigned DRMC_BANK_BIT_32 = 20;
    localparam int unsigned DRMC_BANK_BIT_64 = 21;

    // Prescaler
    localparam int unsigned DRMC_PRESCALE_W = 12;

    // Refresh cycle length on the memory side
    localparam int unsigned DRMC_CLK_PERIOD_NS = 20;
    localparam int unsigned DRMC_REFRESH_NS = 140;
    localparam int unsigned DRMC_REFRESH_CYC =
        (DRMC_REFRESH_NS + DRMC_CLK_PERIOD_NS - 1) / DRMC_CLK_PERIOD_NS;
    localparam int unsigned DRMC_RCNT_W = 4;

    typedef enum logic [DRMC_STATE_W-1:0] {
        DRMC_IDLE = 3'b000,
        DRMC_HOLD = 3'b001,
        DRMC_REFRESH = 3'b010,
        DRMC_SELF_WAIT = 3'b011,
        DRMC_SELF = 3'b100
    } drmc_state_t;

endpackage

// *** hdl/drmc_interval_timer.sv ***
// Prescaled interval timer that paces refresh requests
`timescale 1ns/1ps
`default_nettype none
module drmc_interval_timer
    import drmc_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Configuration
    input wire logic [DRMC_SEL_W-1:0] clock_sel_i,
    input wire logic [CNT_W-1:0] constant_i,
    // Software access to the count and flag
    input wire logic count_wr_i,
    input wire logic [CNT_W-1:0] count_wdata_i,
    input wire logic flag_clear_i,
    // Results
    output logic [CNT_W-1:0] count_o,
    output logic match_o,
    output logic flag_o
);

    logic [DRMC_PRESCALE_W-1:0] prescale;
    logic [DRMC_PRESCALE_W-1:0] tick_mask;
    logic tick;
    logic at_constant;

    // Select 0 stops the timer; select n ticks every 4^(n-1)... 2^(2n-2) clocks
    assign tick_mask = (DRMC_PRESCALE_W'(1) << (2 * (clock_sel_i - 1'b1))) - 1'b1;
    assign tick = (clock_sel_i != '0) && ((prescale & tick_mask) == tick_mask);
    assign at_constant = (count_o == constant_i);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    // The timer runs whatever the refresh setting, so it doubles as a plain timer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count_o <= '0;
            match_o <= 1'b0;
        end else if (count_wr_i) begin
            count_o <= count_wdata_i;
            match_o <= 1'b0;
        end else if (tick) begin
            count_o <= at_constant ? '0 : count_o + 1'b1;
            match_o <= at_constant;
        end else begin
            match_o <= 1'b0;
        end
    end

    // A match in the clearing cycle keeps the flag set
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flag_o <= 1'b0;
        end else if (tick && at_constant) begin
            flag_o <= 1'b1;
        end else if (flag_clear_i) begin
            flag_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** hdl/drmc_refresh_control.sv ***
// Refresh mode control: registers, refresh sequencing, self-refresh and EDO sampling
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module drmc_refresh_control
    import drmc_pkg::*;
#(
    parameter int unsigned CNT_W = 8,
    parameter int unsigned REFRESH_CYC = DRMC_REFRESH_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [DRMC_ADDR_W-1:0] addr_i,
    input wire logic [DRMC_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DRMC_DATA_W-1:0] rdata_o,
    // Memory bus status
    input wire logic bus_cycle_active_i,
    input wire logic mem_is_dram_i,
    input wire logic [DRMC_EXT_ADDR_W-1:0] ext_addr_i,
    // Memory control
    output logic refresh_start_o,
    output logic refresh_active_o,
    output logic self_refresh_o,
    output logic edo_late_sample_o,
    output logic bank_sel_o,
    output logic timer_flag_o
);

    // Mode register
    logic refresh_enable_bit;
    logic refresh_kind_select;
    logic extended_data_out_sampling;
    logic wide_bus;

    // Timer registers
    logic [CNT_W-1:0] refresh_timer_constant;
    logic [DRMC_SEL_W-1:0] refresh_timer_clock_sel;
    logic [CNT_W-1:0] refresh_timer_count;
    logic timer_match;
    logic timer_flag;

    // Sequencer
    drmc_state_t state;
    drmc_state_t next_state;
    logic [DRMC_RCNT_W-1:0] refresh_cnt;
    logic overrun;

    // Address decode
    logic sel_mode;
    logic sel_count;
    logic sel_const;
    logic sel_tctrl;
    logic sel_status;
    logic wr_mode;
    logic wr_count;
    logic wr_const;
    logic wr_tctrl;
    logic wr_status;
    logic flag_clear;
    logic [DRMC_DATA_W-1:0] read_mux;
    logic [DRMC_DATA_W-1:0] mode_word;
    logic [DRMC_DATA_W-1:0] tctrl_word;
    logic [DRMC_DATA_W-1:0] status_word;

    // Refresh decisions
    logic timed_mode;
    logic self_mode;
    logic refresh_request;
    logic refresh_done;
    logic request_lost;
    logic next_bank_sel;
    logic next_edo_late;
    logic refresh_busy;
    logic in_self;

    // Full decode so that aliases cannot reach the mode bits
    assign sel_mode = (addr_i == DRMC_OFS_MODE);
    assign sel_count = (addr_i == DRMC_OFS_COUNT);
    assign sel_const = (addr_i == DRMC_OFS_CONST);
    assign sel_tctrl = (addr_i == DRMC_OFS_TCTRL);
    assign sel_status = (addr_i == DRMC_OFS_STATUS);
    assign wr_mode = wr_i && sel_mode;
    assign wr_count = wr_i && sel_count;
    assign wr_const = wr_i && sel_const;
    assign wr_tctrl = wr_i && sel_tctrl;
    assign wr_status = wr_i && sel_status;

    // Writing 0 to the match flag clears it; writing 1 leaves it alone
    assign flag_clear = wr_tctrl && !wdata_i[DRMC_BIT_MATCH];

    // With refresh off the kind bit has no effect at all
    assign timed_mode = refresh_enable_bit && !refresh_kind_select;
    assign self_mode = refresh_enable_bit && refresh_kind_select;

    // Timer matches become refresh requests only in timed mode
    assign refresh_request = timer_match && timed_mode;
    assign refresh_done = (refresh_cnt == DRMC_RCNT_W'(REFRESH_CYC - 1));

    // A request is lost only if one is already waiting or running
    assign refresh_busy = (state == DRMC_HOLD) || (state == DRMC_REFRESH);
    assign request_lost = refresh_request && refresh_busy;

    // Requests form in self-refresh only in the cycle after a switch to timed mode and are dropped, so nothing can queue there
    assign in_self = (state == DRMC_SELF);

    // Mode bits change only on a write of the mode word
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            refresh_enable_bit <= DRMC_RST_BIT;
            refresh_kind_select <= DRMC_RST_BIT;
            extended_data_out_sampling <= DRMC_RST_BIT;
            wide_bus <= DRMC_RST_BIT;
        end else if (wr_mode) begin
            refresh_enable_bit <= wdata_i[DRMC_BIT_ENABLE];
            refresh_kind_select <= wdata_i[DRMC_BIT_KIND];
            extended_data_out_sampling <= wdata_i[DRMC_BIT_EDO];
            wide_bus <= wdata_i[DRMC_BIT_WIDE_BUS];
        end
    end

    // A new constant is compared from the next timer tick on
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            refresh_timer_constant <= '0;
            refresh_timer_clock_sel <= '0;
        end else begin
            if (wr_const) begin
                refresh_timer_constant <= wdata_i[CNT_W-1:0];
            end
            if (wr_tctrl) begin
                refresh_timer_clock_sel <= wdata_i[DRMC_SEL_LSB +: DRMC_SEL_W];
            end
        end
    end

    // Runs whatever the enable bit says, so software keeps a plain timer
    drmc_interval_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clock_sel_i(refresh_timer_clock_sel),
        .constant_i(refresh_timer_constant),
        .count_wr_i(wr_count),
        .count_wdata_i(wdata_i[CNT_W-1:0]),
        .flag_clear_i(flag_clear),
        .count_o(refresh_timer_count),
        .match_o(timer_match),
        .flag_o(timer_flag)
    );

    // Sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            DRMC_IDLE: begin
                // Self mode outranks a timed request
                if (self_mode) begin
                    next_state = bus_cycle_active_i ? DRMC_SELF_WAIT : DRMC_SELF;
                end else if (refresh_request) begin
                    next_state = bus_cycle_active_i ? DRMC_HOLD : DRMC_REFRESH;
                end
            end
            DRMC_HOLD: begin
                // A held request dies if refresh is switched off before the bus frees
                if (!timed_mode) begin
                    next_state = DRMC_IDLE;
                end else if (!bus_cycle_active_i) begin
                    next_state = DRMC_REFRESH;
                end
            end
            DRMC_REFRESH: begin
                if (refresh_done) begin
                    next_state = DRMC_IDLE;
                end
            end
            DRMC_SELF_WAIT: begin
                // Leaving the mode while waiting abandons the entry
                if (!self_mode) begin
                    next_state = DRMC_IDLE;
                end else if (!bus_cycle_active_i) begin
                    next_state = DRMC_SELF;
                end
            end
            DRMC_SELF: begin
                // Requests are simply not looked at here
                if (!self_mode) begin
                    next_state = DRMC_IDLE;
                end
            end
            default: begin
                next_state = DRMC_IDLE;
            end
        endcase
    end

    // Illegal codes fall back to idle through the default branch
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= DRMC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Length of one refresh; parked at zero outside it
    always_ff @(posedge clk_i) begin
        if (reset_i || state != DRMC_REFRESH) begin
            refresh_cnt <= '0;
        end else begin
            refresh_cnt <= refresh_cnt + 1'b1;
        end
    end

    // Sticky overrun flag, set wins over a software clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            overrun <= 1'b0;
        end else if (request_lost) begin
            overrun <= 1'b1;
        end else if (wr_status && wdata_i[DRMC_BIT_OVERRUN]) begin
            overrun <= 1'b0;
        end
    end

    // A refresh in progress is not dropped if software turns refresh off;
    // the sequencer leaves DRMC_REFRESH only once refresh_done marks its full length.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            refresh_start_o <= 1'b0;
            refresh_active_o <= 1'b0;
            self_refresh_o <= 1'b0;
        end else begin
            refresh_start_o <= (next_state == DRMC_REFRESH) && (state != DRMC_REFRESH);
            refresh_active_o <= (next_state == DRMC_REFRESH);
            self_refresh_o <= (next_state == DRMC_SELF);
        end
    end

    // Late sampling applies to DRAM accesses only
    assign next_edo_late = extended_data_out_sampling && mem_is_dram_i;

    // Bank bit of the 256K x 32 x 2-bank device depends on bus width
    assign next_bank_sel = wide_bus ? ext_addr_i[DRMC_BANK_BIT_64]
                                    : ext_addr_i[DRMC_BANK_BIT_32];

    // Registered so that every output leaves straight from a flip-flop
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            edo_late_sample_o <= 1'b0;
            bank_sel_o <= 1'b0;
            timer_flag_o <= 1'b0;
        end else begin
            edo_late_sample_o <= next_edo_late;
            bank_sel_o <= next_bank_sel;
            timer_flag_o <= timer_flag;
        end
    end

    // Read path
    always_comb begin
        mode_word = '0;
        mode_word[DRMC_BIT_EDO] = extended_data_out_sampling;
        mode_word[DRMC_BIT_KIND] = refresh_kind_select;
        mode_word[DRMC_BIT_ENABLE] = refresh_enable_bit;
        mode_word[DRMC_BIT_WIDE_BUS] = wide_bus;
    end

    // The live flag; the output copy lags it by one cycle
    always_comb begin
        tctrl_word = '0;
        tctrl_word[DRMC_SEL_LSB +: DRMC_SEL_W] = refresh_timer_clock_sel;
        tctrl_word[DRMC_BIT_MATCH] = timer_flag;
    end

    always_comb begin
        status_word = '0;
        status_word[DRMC_STATE_W-1:0] = state;
        status_word[DRMC_BIT_OVERRUN] = overrun;
        status_word[DRMC_BIT_SELF] = in_self;
    end

    // Unmapped addresses read as zero
    assign read_mux =
        sel_mode ? mode_word :
        sel_count ? DRMC_DATA_W'(refresh_timer_count) :
        sel_const ? DRMC_DATA_W'(refresh_timer_constant) :
        sel_tctrl ? tctrl_word :
        sel_status ? status_word : '0;

    // Data stand for exactly the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (reset_i || !rd_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= read_mux;
        end
    end

endmodule
`default_nettype wire

// *** verification/drmc_refresh_control_sva.sv ***
// Port-level assertions for the refresh mode control block
`timescale 1ns/1ps
`default_nettype none
module drmc_refresh_control_sva
    import drmc_pkg::*;
#(
    parameter int unsigned CNT_W = 8,
    parameter int unsigned REFRESH_CYC = DRMC_REFRESH_CYC
) (
    // Inputs of the design
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [DRMC_ADDR_W-1:0] addr_i,
    input wire logic [DRMC_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic bus_cycle_active_i,
    input wire logic mem_is_dram_i,
    input wire logic [DRMC_EXT_ADDR_W-1:0] ext_addr_i,
    // Outputs of the design
    input wire logic [DRMC_DATA_W-1:0] rdata_o,
    input wire logic refresh_start_o,
    input wire logic refresh_active_o,
    input wire logic self_refresh_o,
    input wire logic edo_late_sample_o,
    input wire logic bank_sel_o,
    input wire logic timer_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic [3:0] mode;
    logic [7:0] act;
    // Mode mirror updates on the write edge, as the design does
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode <= 4'h0;
            act <= 8'h00;
        end else begin
            if (wr_i && addr_i == DRMC_OFS_MODE) begin
                mode <= wdata_i[3:0];
            end
            act <= refresh_active_o ? act + 8'h01 : 8'h00;
        end
    end
    property p_off;
        !mode[2] && !$past(mode[2]) |-> !self_refresh_o && !refresh_start_o;
    endproperty
    a_off: assert property (p_off) else $error("memory activity while disabled");
    property p_len;
        $fell(refresh_active_o) |-> act == REFRESH_CYC;
    endproperty
    a_len: assert property (p_len) else $error("refresh length wrong");
    property p_cap;
        refresh_active_o |-> act < REFRESH_CYC;
    endproperty
    a_cap: assert property (p_cap) else $error("refresh too long");
    property p_start;
        refresh_start_o |-> refresh_active_o && !$past(refresh_active_o)
            && !$past(bus_cycle_active_i) && $past(mode[2]) && !$past(mode[1]);
    endproperty
    a_start: assert property (p_start) else $error("refresh start misplaced");
    property p_self;
        $rose(self_refresh_o) |-> $past(mode[2] && mode[1]) && !$past(bus_cycle_active_i);
    endproperty
    a_self: assert property (p_self) else $error("self refresh entry wrong");
    property p_drop;
        self_refresh_o |-> !refresh_start_o && !refresh_active_o;
    endproperty
    a_drop: assert property (p_drop) else $error("refresh during self refresh");
    property p_edo;
        edo_late_sample_o == $past(mode[0] && mem_is_dram_i);
    endproperty
    a_edo: assert property (p_edo) else $error("sampling select wrong");
    property p_bank;
        !$past(reset_i) |->
            bank_sel_o == $past(mode[3] ? ext_addr_i[21] : ext_addr_i[20]);
    endproperty
    a_bank: assert property (p_bank) else $error("bank bit wrong");
    property p_rd;
        $past(rd_i) && $past(addr_i) == DRMC_OFS_MODE |-> rdata_o == {28'h0000000, $past(mode)};
    endproperty
    a_rd: assert property (p_rd) else $error("mode readback wrong");
    property p_quiet;
        !$past(rd_i) |-> rdata_o == 32'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("read data outside read");
endmodule
bind drmc_refresh_control drmc_refresh_control_sva #(
    .CNT_W(CNT_W),
    .REFRESH_CYC(REFRESH_CYC)
) u_sva (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .bus_cycle_active_i,
    .mem_is_dram_i, .ext_addr_i, .rdata_o, .refresh_start_o, .refresh_active_o,
    .self_refresh_o, .edo_late_sample_o, .bank_sel_o, .timer_flag_o);
`default_nettype wire

// *** verification/drmc_mem_model.sv ***
// Behavioural memory side: bus cycles and access attributes
`timescale 1ns/1ps
`default_nettype none
module drmc_mem_model
    import drmc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Bench command and controller state
    input wire logic hold_i,
    input wire logic refresh_active_i,
    input wire logic self_refresh_i,
    // Bus status towards the controller
    output logic bus_cycle_active_o,
    output logic mem_is_dram_o,
    output logic [DRMC_EXT_ADDR_W-1:0] ext_addr_o
);
    integer seed = 63791;
    initial begin
        bus_cycle_active_o = 1'h0;
        mem_is_dram_o = 1'h0;
        ext_addr_o = 27'h0;
    end
    // A bus cycle never begins while the memory refreshes or sleeps
    always @(posedge clk_i) begin
        if (reset_i || !hold_i) begin
            bus_cycle_active_o <= 1'h0;
        end else if (!refresh_active_i && !self_refresh_i) begin
            bus_cycle_active_o <= 1'h1;
        end
        mem_is_dram_o <= 1'($random(seed));
        ext_addr_o <= 27'($random(seed));
    end
endmodule
`default_nettype wire

// *** verification/drmc_refresh_control_tb.sv ***
// Self-checking testbench for the refresh mode control block
`timescale 1ns/1ps
`default_nettype none
module drmc_refresh_control_tb
    import drmc_pkg::*;
;
    logic clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic [DRMC_ADDR_W-1:0] addr_i = 8'h00;
    logic [DRMC_DATA_W-1:0] wdata_i = 32'h0;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic hold = 1'h0;
    wire logic [DRMC_DATA_W-1:0] rdata_o;
    wire logic bus, dram, start, act, self, edo, bank, flag;
    wire logic [DRMC_EXT_ADDR_W-1:0] ea;
    integer seed = 63791;
    int err_total = 0;
    int compares = 0;
    int starts = 0;
    int cyc = 0;
    int last = 0;
    int gap = 0;
    int n;
    logic [31:0] r;
    logic pd;
    logic [DRMC_EXT_ADDR_W-1:0] pa;
    always #10 clk_i = ~clk_i;
    drmc_refresh_control #(.CNT_W(8), .REFRESH_CYC(3)) u_dut (.clk_i, .reset_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .rdata_o, .bus_cycle_active_i(bus), .mem_is_dram_i(dram),
        .ext_addr_i(ea), .refresh_start_o(start), .refresh_active_o(act),
        .self_refresh_o(self), .edo_late_sample_o(edo), .bank_sel_o(bank),
        .timer_flag_o(flag));
    drmc_mem_model u_mem (.clk_i, .reset_i, .hold_i(hold), .refresh_active_i(act),
        .self_refresh_i(self), .bus_cycle_active_o(bus), .mem_is_dram_o(dram),
        .ext_addr_o(ea));
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (start === 1'h1) begin
            starts <= starts + 1;
            gap <= cyc - last;
            last <= cyc;
        end
    end
    function automatic logic exp_bank(input logic w, input logic [26:0] a);
        return w ? a[DRMC_BANK_BIT_64] : a[DRMC_BANK_BIT_32];
    endfunction
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic test_done();
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'h1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string w);
        @(posedge clk_i);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1;
        chk(w, e, rdata_o & m);
    endtask
    // Bounded wait on start pulse or self-refresh level
    task automatic wait_sig(input bit s, input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge clk_i);
            #1;
            if ((s ? self : start) === v) return;
        end
        chk("wait", v, s ? self : start);
        test_done();
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'h0;
        rd(DRMC_OFS_MODE, 32'hFFFFFFFF, 32'h0, "mode");
        rd(8'h14, 32'hFFFFFFFF, 32'h0, "unmapped");
        wr(DRMC_OFS_CONST, 32'h5);
        wr(DRMC_OFS_TCTRL, 32'h1);
        wr(DRMC_OFS_MODE, 32'h2);
        repeat (20) @(posedge clk_i);
        #1;
        chk("flag", 32'h1, flag);
        chk("starts", 32'h0, starts);
        chk("self", 32'h0, self);
        wr(DRMC_OFS_MODE, 32'h4);
        wait_sig(0, 1, 20);
        wait_sig(0, 1, 20);
        @(posedge clk_i);
        #1;
        chk("period", 32'h6, gap);
        hold <= 1'h1;
        repeat (16) @(posedge clk_i);
        rd(DRMC_OFS_STATUS, 32'h17, 32'h11, "hold");
        hold <= 1'h0;
        wait_sig(0, 1, 4);
        // Stop the timer so no request can set the overrun again before the read
        wr(DRMC_OFS_TCTRL, 32'h80);
        wr(DRMC_OFS_STATUS, 32'h10);
        rd(DRMC_OFS_STATUS, 32'h10, 32'h0, "overrun");
        wr(DRMC_OFS_TCTRL, 32'h81);
        hold <= 1'h1;
        repeat (4) @(posedge clk_i);
        wr(DRMC_OFS_MODE, 32'h6);
        repeat (4) @(posedge clk_i);
        #1;
        chk("self wait", 32'h0, self);
        hold <= 1'h0;
        wait_sig(1, 1, 12);
        rd(DRMC_OFS_STATUS, 32'h27, 32'h24, "self");
        n = starts;
        repeat (20) @(posedge clk_i);
        chk("discard", n, starts);
        wr(DRMC_OFS_MODE, 32'h4);
        wait_sig(1, 0, 4);
        for (n = 0; n < 30; n++) begin
            r = $random(seed);
            wr(DRMC_OFS_MODE, {28'h0, r[3], 2'h0, r[0] & r[2]});
            #1;
            repeat (6) begin
                pd = dram;
                pa = ea;
                @(posedge clk_i);
                #1;
                chk("edo", r[0] & r[2] & pd, edo);
                chk("bank", exp_bank(r[3], pa), bank);
            end
        end
        test_done();
    end
endmodule
`default_nettype wire
